// *** verilog/lpwg_wake_guard.sv ***
// Low-power entry and wake guard with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module lpwg_wake_guard
    import lpwg_pkg::*;
#(
    parameter logic [15:0] SLOW_SETTLE_CYC =
        16'(T_SLOW_SETTLE_NS / CLK_PERIOD_NS)
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_puc,
    input wire logic i_wake_irq,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    output logic o_device_reset,
    output logic o_cpu_run,
    output logic o_osc_overshoot,
    output logic o_sub_clk_fast,
    output logic o_main_clk_fast,
    output logic [2:0] o_main_clock_divide_field
);

    typedef struct packed {
        lpwg_state_t st;
        logic [2:0] lpm;
        logic [2:0] div;
        logic req_en;
        logic src_xt;
        logic [1:0] core_lvl;
        logic lo_fp;
        logic hi_off;
        logic lo_settle;
        logic hi_settle;
        logic raise_fp;
        logic hazard;
        logic [15:0] lo_cnt;
        logic [15:0] hi_cnt;
        logic [15:0] hold_cnt;
        logic [15:0] osc_cnt;
        logic [15:0] win_cnt;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic dev_rst;
        logic overshoot;
        logic sub_fast;
        logic main_fast;
        logic cpu_run;
    } lpwg_regs_t;

    localparam lpwg_regs_t REGS_RST = '{
        st: ST_ACTIVE,
        div: DIV_RST,
        req_en: REQ_EN_RST,
        waitreq: 1'b1,
        cpu_run: 1'b1,
        default: '0
    };

    lpwg_regs_t r;
    lpwg_regs_t n;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic core_rst;
        logic wr;
        logic [31:0] wd;
        logic [31:0] rd;
        ev = '0;
        clr = '0;
        core_rst = 1'b0;
        rd = 32'h0;
        n = r;
        n.dev_rst = 1'b0;
        wd = i_avs_writedata;
        wr = i_avs_write && !r.waitreq && i_avs_byteenable[0];

        // Supervisor settle delays, overshoot and entry-window countdowns
        if (r.lo_settle) begin
            if (r.lo_cnt == 16'h0000) begin
                n.lo_settle = 1'b0;
                ev[IRQ_SETTLE] = 1'b1;
                core_rst = r.raise_fp;
            end else begin
                n.lo_cnt = r.lo_cnt - 16'h0001;
            end
        end
        if (r.hi_settle) begin
            if (r.hi_cnt == 16'h0000) begin
                n.hi_settle = 1'b0;
                ev[IRQ_SETTLE] = 1'b1;
            end else begin
                n.hi_cnt = r.hi_cnt - 16'h0001;
            end
        end
        if (r.osc_cnt != 16'h0000) begin
            n.osc_cnt = r.osc_cnt - 16'h0001;
        end
        if (r.win_cnt != 16'h0000) begin
            n.win_cnt = r.win_cnt - 16'h0001;
        end

        // -------------------------------------------------------------------
        // Power state machine
        // -------------------------------------------------------------------
        case (r.st)
            ST_ACTIVE: begin
                n.st = ST_ACTIVE;
            end
            ST_LPM: begin
                if (i_wake_irq) begin
                    if (r.hazard && r.win_cnt != 16'h0000) begin
                        n.st = ST_HANG;
                        ev[IRQ_HANG] = 1'b1;
                    end else if (r.lpm != LPM_CODE_2) begin
                        n.st = ST_HOLD;
                        n.osc_cnt = OVERSHOOT_CYC;
                        n.hold_cnt = (r.lo_fp ? FAST_SETTLE_CYC
                                      : SLOW_SETTLE_CYC) - 16'h0001;
                    end else begin
                        n.st = ST_ACTIVE;
                        ev[IRQ_WAKE] = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                if (r.hold_cnt == 16'h0000) begin
                    n.st = ST_ACTIVE;
                    ev[IRQ_WAKE] = 1'b1;
                end else begin
                    n.hold_cnt = r.hold_cnt - 16'h0001;
                end
            end
            ST_HANG: begin
                n.st = ST_HANG;
            end
            default: begin
                n.st = ST_ACTIVE;
            end
        endcase

        // -------------------------------------------------------------------
        // Register slave
        // -------------------------------------------------------------------
        case (i_avs_address)
            ADDR_CLK_DIV: rd = {29'h0, r.div};
            ADDR_CLK_REQ: rd = {30'h0, r.src_xt, r.req_en};
            ADDR_LO_SUP: rd = {29'h0, r.core_lvl, r.lo_fp};
            ADDR_HI_SUP: rd = {31'h0, r.hi_off};
            ADDR_PWR_FLAG: rd = {30'h0, r.hi_settle, r.lo_settle};
            ADDR_LPM_ENTRY: rd = {27'h0, r.st, r.lpm};
            ADDR_IRQ_STATUS: rd = {28'h0, r.irq_st};
            ADDR_IRQ_MASK: rd = {28'h0, r.irq_mask};
            default: rd = 32'h0;
        endcase
        if ((i_avs_read || i_avs_write) && r.waitreq) begin
            n.waitreq = 1'b0;
            n.rdata = rd;
        end else begin
            n.waitreq = 1'b1;
        end
        if (wr) begin
            case (i_avs_address)
                ADDR_CLK_DIV: n.div = wd[2:0];
                ADDR_CLK_REQ: begin
                    n.req_en = wd[0];
                    n.src_xt = wd[1];
                end
                ADDR_LO_SUP: begin
                    n.lo_fp = wd[0];
                    n.core_lvl = wd[2:1];
                    n.lo_settle = 1'b1;
                    n.lo_cnt = (wd[0] ? FAST_SETTLE_CYC
                                : SLOW_SETTLE_CYC) - 16'h0001;
                    n.raise_fp = wd[0] && (wd[2:1] > r.core_lvl);
                end
                ADDR_HI_SUP: begin
                    n.hi_off = wd[0];
                    n.hi_settle = 1'b1;
                    n.hi_cnt = SLOW_SETTLE_CYC - 16'h0001;
                end
                ADDR_LPM_ENTRY: begin
                    if (r.st == ST_ACTIVE && (wd[2:0] == LPM_CODE_2
                        || wd[2:0] == LPM_CODE_3
                        || wd[2:0] == LPM_CODE_4)) begin
                        n.st = ST_LPM;
                        n.lpm = wd[2:0];
                        n.win_cnt = ENTRY_WIN_CYC;
                        n.hazard = (r.lo_settle || r.hi_settle)
                                   && r.hi_off && r.lo_fp;
                    end
                end
                ADDR_IRQ_STATUS: clr = wd[IRQ_W-1:0];
                ADDR_IRQ_MASK: n.irq_mask = wd[IRQ_W-1:0];
                default: n.div = r.div;
            endcase
        end

        // -------------------------------------------------------------------
        // Clear resets and interrupts
        // -------------------------------------------------------------------
        ev[IRQ_CORE_RST] = core_rst;
        if (core_rst || i_puc) begin
            n.st = REGS_RST.st;
            n.lpm = REGS_RST.lpm;
            n.div = REGS_RST.div;
            n.req_en = REGS_RST.req_en;
            n.src_xt = REGS_RST.src_xt;
            n.core_lvl = REGS_RST.core_lvl;
            n.lo_fp = REGS_RST.lo_fp;
            n.hi_off = REGS_RST.hi_off;
            n.lo_settle = 1'b0;
            n.hi_settle = 1'b0;
            n.raise_fp = 1'b0;
            n.hazard = 1'b0;
            n.hold_cnt = 16'h0000;
            n.osc_cnt = 16'h0000;
            n.win_cnt = 16'h0000;
            n.dev_rst = core_rst;
        end
        n.irq_st = (r.irq_st & ~clr) | ev;
        n.irq = |(n.irq_st & n.irq_mask);
        n.overshoot = n.osc_cnt != 16'h0000;
        n.sub_fast = n.overshoot && !n.src_xt;
        n.main_fast = n.overshoot && n.st == ST_ACTIVE
                      && n.div == DIV_FULL;
        n.cpu_run = n.st == ST_ACTIVE;
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= REGS_RST;
        end else if (i_ce) begin
            r <= n;
        end
    end

    assign o_avs_readdata = r.rdata;
    assign o_avs_waitrequest = r.waitreq;
    assign o_irq = r.irq;
    assign o_device_reset = r.dev_rst;
    assign o_cpu_run = r.cpu_run;
    assign o_osc_overshoot = r.overshoot;
    assign o_sub_clk_fast = r.sub_fast;
    assign o_main_clk_fast = r.main_fast;
    assign o_main_clock_divide_field = r.div;

endmodule

// *** shared/lpwg_pkg.sv ***
// Constants and types shared by the low-power wake guard
package lpwg_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_OVERSHOOT_NS = 6000;
    localparam int T_FAST_SETTLE_NS = 2000;
    localparam int T_SLOW_SETTLE_NS = 150000;
    localparam int T_ENTRY_WIN_NS = 1000;
    localparam logic [15:0] OVERSHOOT_CYC =
        16'(T_OVERSHOOT_NS / CLK_PERIOD_NS);
    localparam logic [15:0] FAST_SETTLE_CYC =
        16'(T_FAST_SETTLE_NS / CLK_PERIOD_NS);
    localparam logic [15:0] ENTRY_WIN_CYC =
        16'(T_ENTRY_WIN_NS / CLK_PERIOD_NS);

    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [4:0] ADDR_CLK_DIV = 5'h00;
    localparam logic [4:0] ADDR_CLK_REQ = 5'h04;
    localparam logic [4:0] ADDR_LO_SUP = 5'h08;
    localparam logic [4:0] ADDR_HI_SUP = 5'h0c;
    localparam logic [4:0] ADDR_PWR_FLAG = 5'h10;
    localparam logic [4:0] ADDR_LPM_ENTRY = 5'h14;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h18;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h1c;

    // -------------------------------------------------------------------
    // Field values and reset values
    // -------------------------------------------------------------------
    localparam logic [2:0] DIV_FULL = 3'h0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic REQ_EN_RST = 1'h1;
    localparam logic [2:0] LPM_CODE_2 = 3'h2;
    localparam logic [2:0] LPM_CODE_3 = 3'h3;
    localparam logic [2:0] LPM_CODE_4 = 3'h4;

    // -------------------------------------------------------------------
    // Interrupt bits
    // -------------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_CORE_RST = 1;
    localparam int IRQ_HANG = 2;
    localparam int IRQ_SETTLE = 3;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_LPM,
        ST_HOLD,
        ST_HANG
    } lpwg_state_t;

endpackage

// *** verif/lpwg_wake_guard_properties.sv ***
// Port-level checks on the wake guard
`timescale 1ns/100ps
module lpwg_props
    import lpwg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_puc,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_device_reset,
    input wire logic o_cpu_run,
    input wire logic o_osc_overshoot,
    input wire logic o_sub_clk_fast,
    input wire logic o_main_clk_fast,
    input wire logic [2:0] o_main_clock_divide_field
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    logic [15:0] ov_cnt;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) ov_cnt <= 16'h0;
        else if (o_osc_overshoot) ov_cnt <= ov_cnt + 16'h1;
        else ov_cnt <= 16'h0;
    end
    property p_wait_one;
        $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_wait_ans;
        (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce
            |=> !o_avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
    property p_ov_len;
        $fell(o_osc_overshoot) |-> ov_cnt == OVERSHOOT_CYC;
    endproperty
    a_ov_len: assert property (p_ov_len) else $error("overshoot length");
    property p_sub_fast;
        o_sub_clk_fast |-> o_osc_overshoot;
    endproperty
    a_sub_fast: assert property (p_sub_fast) else $error("sub fast");
    property p_main_fast;
        o_main_clk_fast |-> o_osc_overshoot && o_cpu_run
            && o_main_clock_divide_field == DIV_FULL;
    endproperty
    a_main_fast: assert property (p_main_fast) else $error("main fast");
    property p_hold;
        $rose(o_osc_overshoot) |-> !o_cpu_run;
    endproperty
    a_hold: assert property (p_hold) else $error("cpu not held");
    property p_dev_rst;
        o_device_reset |=> !o_device_reset ##1 o_cpu_run;
    endproperty
    a_dev_rst: assert property (p_dev_rst) else $error("reset pulse");
    property p_puc;
        i_puc && i_ce |-> ##2 o_cpu_run;
    endproperty
    a_puc: assert property (p_puc) else $error("clear reset ignored");
endmodule
bind lpwg_wake_guard lpwg_props u_props (.i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n), .i_ce(i_ce), .i_puc(i_puc),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_device_reset(o_device_reset), .o_cpu_run(o_cpu_run),
    .o_osc_overshoot(o_osc_overshoot), .o_sub_clk_fast(o_sub_clk_fast),
    .o_main_clk_fast(o_main_clk_fast),
    .o_main_clock_divide_field(o_main_clock_divide_field));

// *** verif/lpwg_fw_model.sv ***
// Firmware-side bus master model for the wake guard
`timescale 1ns/100ps
module lpwg_fw_model (
    input wire logic i_clk_sys,
    input wire logic i_avs_waitrequest,
    input wire logic [31:0] i_avs_readdata,
    output logic [4:0] o_avs_address,
    output logic o_avs_read,
    output logic o_avs_write,
    output logic [31:0] o_avs_writedata,
    output logic [3:0] o_avs_byteenable
);
    initial begin
        o_avs_address = 5'h00;
        o_avs_read = 1'b0;
        o_avs_write = 1'b0;
        o_avs_writedata = 32'h0;
        o_avs_byteenable = 4'h0;
    end
    // One access, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [4:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
        @(posedge i_clk_sys);
        o_avs_address <= a;
        o_avs_read <= !wr;
        o_avs_write <= wr;
        o_avs_writedata <= d;
        o_avs_byteenable <= be;
        do @(posedge i_clk_sys); while (i_avs_waitrequest !== 1'b0);
        q = i_avs_readdata;
        o_avs_read <= 1'b0;
        o_avs_write <= 1'b0;
        o_avs_writedata <= ~d;
    endtask
    // Wait after wake per core level, in system clock cycles
    function automatic int wake_wait(input logic [1:0] lvl, input logic m);
        case (lvl)
            2'h0: wake_wait = 32;
            2'h1: wake_wait = 48;
            2'h2: wake_wait = m ? 64 : 80;
            default: wake_wait = m ? 80 : 100;
        endcase
    endfunction
endmodule

// *** verif/test_low_power_wake_guard.sv ***
// Self-checking bench for the low-power wake guard
`timescale 1ns/100ps
module test_low_power_wake_guard;
    import lpwg_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_puc = 1'b0;
    logic i_wake_irq = 1'b0;
    logic ce = 1'b1;
    logic [4:0] adr;
    logic rd_s, wr_s, wreq, irq, dres, run, ovs, subf, mainf;
    logic [31:0] wd, rdat, q;
    logic [3:0] be;
    logic [2:0] div;
    int err_total = 0;
    int tests_run = 0;
    int n;
    always #2 i_clk_sys = ~i_clk_sys;
    lpwg_wake_guard #(.SLOW_SETTLE_CYC(16'h0028)) DUT (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .i_ce(ce), .i_puc(i_puc),
        .i_wake_irq(i_wake_irq), .i_avs_address(adr), .i_avs_read(rd_s),
        .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq),
        .o_device_reset(dres), .o_cpu_run(run), .o_osc_overshoot(ovs),
        .o_sub_clk_fast(subf), .o_main_clk_fast(mainf),
        .o_main_clock_divide_field(div));
    lpwg_fw_model u_fw (.i_clk_sys(i_clk_sys), .i_avs_waitrequest(wreq),
        .i_avs_readdata(rdat), .o_avs_address(adr), .o_avs_read(rd_s),
        .o_avs_write(wr_s), .o_avs_writedata(wd), .o_avs_byteenable(be));
    task automatic chk1(input string s, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk32(input string s, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        u_fw.access(1'b1, a, d, 4'h1, q);
    endtask
    task automatic rd(input logic [4:0] a);
        u_fw.access(1'b0, a, 32'h0, 4'hf, q);
    endtask
    task automatic ticks(input int k);
        repeat (k) @(negedge i_clk_sys);
    endtask
    task automatic t_reset();
        ticks(1);
        chk32("idle outputs", 32'h208,
            {22'h0, run, irq, dres, ovs, subf, mainf, wreq, div});
        rd(ADDR_CLK_REQ);
        chk32("clk_req", 32'h1, q);
        u_fw.access(1'b1, ADDR_CLK_DIV, 32'h1, 4'h0, q);
        rd(ADDR_CLK_DIV);
        chk32("div no enable", 32'h0, q);
        rd(5'h02);
        chk32("unmapped", 32'h0, q);
        $display("test reset done");
    endtask
    task automatic t_ce();
        wr(ADDR_CLK_DIV, 32'h5);
        @(posedge i_clk_sys);
        ce <= 1'b0;
        i_puc <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        i_puc <= 1'b0;
        ce <= 1'b1;
        ticks(2);
        chk32("div frozen", 32'h5, {29'h0, div});
        rd(ADDR_CLK_DIV);
        chk32("div kept", 32'h5, q);
        wr(ADDR_LPM_ENTRY, 32'h5);
        rd(ADDR_LPM_ENTRY);
        chk32("bad mode refused", 32'h0, q);
        $display("test enable done");
    endtask
    task automatic t_wake();
        wr(ADDR_CLK_DIV, 32'h1);
        wr(ADDR_LPM_ENTRY, {29'h0, LPM_CODE_3});
        ticks(2);
        chk1("run in lpm", 1'b0, run);
        @(posedge i_clk_sys) i_wake_irq <= 1'b1;
        for (n = 0; n < 20 && ovs !== 1'b1; n++) ticks(1);
        @(posedge i_clk_sys) i_wake_irq <= 1'b0;
        chk1("overshoot", 1'b1, ovs);
        for (n = 0; n < 100 && run !== 1'b1; n++) ticks(1);
        chk1("hold length", 1'b1, n >= 35 && n <= 42);
        chk1("sub fast", 1'b1, subf);
        chk1("main halved", 1'b0, mainf);
        repeat (u_fw.wake_wait(2'h0, 1'b0)) @(posedge i_clk_sys);
        wr(ADDR_CLK_DIV, 32'h0);
        ticks(2);
        chk1("main fast", 1'b1, mainf);
        wr(ADDR_IRQ_MASK, 32'h1);
        ticks(2);
        chk1("wake irq", 1'b1, irq);
        wr(ADDR_IRQ_STATUS, 32'h1);
        ticks(2);
        chk1("irq cleared", 1'b0, irq);
        wr(ADDR_CLK_REQ, 32'h3);
        ticks(2);
        chk1("sub from crystal", 1'b0, subf);
        for (n = 0; n < 2000 && ovs !== 1'b0; n++) ticks(1);
        chk1("overshoot end", 1'b0, ovs);
        chk1("main after overshoot", 1'b0, mainf);
        $display("test wake done");
    endtask
    task automatic settle();
        rd(ADDR_PWR_FLAG);
        for (n = 0; n < 400 && q[1:0] !== 2'h0; n++) rd(ADDR_PWR_FLAG);
        chk32("flags", 32'h0, {30'h0, q[1:0]});
    endtask
    task automatic t_core();
        wr(ADDR_LO_SUP, 32'h1);
        settle();
        wr(ADDR_LO_SUP, 32'h3);
        for (n = 0; n < 700 && dres !== 1'b1; n++) ticks(1);
        chk1("core reset", 1'b1, dres);
        chk1("fast settle", 1'b1, n >= 494 && n <= 506);
        rd(ADDR_IRQ_STATUS);
        chk1("core irq", 1'b1, q[1]);
        wr(ADDR_IRQ_STATUS, 32'hf);
        wr(ADDR_LO_SUP, 32'h2);
        settle();
        rd(ADDR_IRQ_STATUS);
        chk1("no core reset", 1'b0, q[IRQ_CORE_RST]);
        $display("test core done");
    endtask
    task automatic t_hang();
        wr(ADDR_HI_SUP, 32'h1);
        wr(ADDR_LO_SUP, 32'h1);
        wr(ADDR_LPM_ENTRY, {29'h0, LPM_CODE_2});
        @(posedge i_clk_sys) i_wake_irq <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_wake_irq <= 1'b0;
        rd(ADDR_LPM_ENTRY);
        chk32("hang state", 32'h3, {30'h0, q[4:3]});
        chk1("run hung", 1'b0, run);
        rd(ADDR_IRQ_STATUS);
        chk1("hang irq", 1'b1, q[IRQ_HANG]);
        @(posedge i_clk_sys) i_puc <= 1'b1;
        @(posedge i_clk_sys) i_puc <= 1'b0;
        ticks(3);
        chk1("run after clear", 1'b1, run);
        rd(ADDR_LPM_ENTRY);
        chk32("state after clear", 32'h0, {30'h0, q[4:3]});
        wr(ADDR_LPM_ENTRY, {29'h0, LPM_CODE_4});
        ticks(2);
        chk1("run in mode 4", 1'b0, run);
        @(posedge i_clk_sys) i_wake_irq <= 1'b1;
        for (n = 0; n < 100 && run !== 1'b1; n++) ticks(1);
        @(posedge i_clk_sys) i_wake_irq <= 1'b0;
        chk1("mode 4 wake", 1'b1, run);
        chk1("mode 4 overshoot", 1'b1, ovs);
        $display("test hang done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_reset();
        t_ce();
        t_wake();
        t_core();
        t_hang();
        results();
    end
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule
